// [hw/onwd_pkg.sv]
// Contract
// RL1: Unused locations program nothing, return node address
// RL2: Bank0 nibble7: data bit3 sets user lock
// RL3: Bank0 nibble8: data bits3-2 set filter select
// RL4: Bank0 nibble10: data bit3 sets identity bit
// RL5: Bank1 nibble6: data bits1-0 set trim field
// RL6: Bank1 nibble7: full nibble sets node address
// RL7: Bank1 nibbles8-14: low nibble user bytes 1-7
// RL8: Bank2 nibble7: data bit1 sets mode bit
// RL9: Bank2 nibbles8-15: high nibble user bytes 1-8
// RL10: Burn only when burn enable set; else mirror only
// RL11: Burn response: node, nibble, 11, bank, content
// RL12: Master waits bit time per programmed bit
// RL13: Locations without target are treated as unused
// RL14: Bits outside target field leave neighbours unchanged
package onwd_pkg;
   // ----------------------------------------
   // Register map and fields
   // ----------------------------------------
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_CMD = 8'h04;
   localparam logic [7:0] REG_STATUS = 8'h08;
   localparam logic [7:0] REG_RESP = 8'h0c;
   localparam logic [7:0] REG_NODE = 8'h10;
   localparam int CTRL_BURN_BIT = 0;
   localparam int CTRL_BANK_LSB = 2;
   localparam int CMD_DATA_LSB = 0;
   localparam int CMD_NIB_LSB = 4;
   localparam int STAT_BUSY_BIT = 0;
   localparam int STAT_BITS_LSB = 4;
   localparam logic [3:0] NODE_RESET = 4'h0;
   localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
   // ----------------------------------------
   // Mirror layout
   // ----------------------------------------
   localparam logic [3:0] IDX_CFG0 = 4'h0;
   localparam logic [3:0] IDX_CFG1 = 4'h1;
   localparam logic [3:0] IDX_CFG2 = 4'h2;
   localparam logic [3:0] IDX_TYPE = 4'h3;
   localparam logic [3:0] IDX_UD1 = 4'h4;
   localparam logic [7:0] MASK_LOCK = 8'h80;
   localparam logic [7:0] MASK_FILTER = 8'hc0;
   localparam logic [7:0] MASK_IDENT = 8'h80;
   localparam logic [7:0] MASK_TRIM = 8'h03;
   localparam logic [7:0] MASK_NODE = 8'h0f;
   localparam logic [7:0] MASK_MODE = 8'h20;
   localparam logic [7:0] MASK_LO = 8'h0f;
   localparam logic [7:0] MASK_HI = 8'hf0;
   localparam logic [3:0] NIB_LOCK = 4'h7;
   localparam logic [3:0] NIB_FILTER = 4'h8;
   localparam logic [3:0] NIB_IDENT = 4'ha;
   localparam logic [3:0] NIB_TRIM = 4'h6;
   localparam logic [3:0] NIB_NODE = 4'h7;
   localparam logic [3:0] NIB_MODE = 4'h7;
   localparam logic [3:0] NIB_UD_FIRST = 4'h8;
   localparam logic [3:0] NIB_UD1_LAST = 4'he;
   localparam logic [1:0] RESP_BURN_TAG = 2'h3;
   localparam logic [7:0] RESP_NOBURN_FILL = 8'h0f;
   // ----------------------------------------
   // Types
   // ----------------------------------------
   typedef struct packed {
      logic used;
      logic [3:0] idx;
      logic [7:0] mask;
      logic hi;
   } onwd_loc_t;
   typedef struct packed {
      logic [3:0] nibble;
      logic [3:0] data;
   } onwd_cmd_t;
   function automatic onwd_loc_t onwd_decode(logic [1:0] bank, logic [3:0] nib);
      onwd_loc_t l;
      l = '{used: 1'b0, idx: IDX_CFG0, mask: 8'h00, hi: 1'b0};
      unique case (bank)
         2'h0:
         begin
            if (nib == NIB_LOCK) l = '{1'b1, IDX_CFG2, MASK_LOCK, 1'b1}; // see RL2
            else if (nib == NIB_FILTER) l = '{1'b1, IDX_TYPE, MASK_FILTER, 1'b1}; // see RL3
            else if (nib == NIB_IDENT) l = '{1'b1, IDX_CFG0, MASK_IDENT, 1'b1}; // see RL4
         end
         2'h1:
         begin
            if (nib == NIB_TRIM) l = '{1'b1, IDX_CFG1, MASK_TRIM, 1'b0}; // see RL5
            else if (nib == NIB_NODE) l = '{1'b1, IDX_CFG2, MASK_NODE, 1'b0}; // see RL6
            else if (nib >= NIB_UD_FIRST && nib <= NIB_UD1_LAST)
               l = '{1'b1, 4'(IDX_UD1 + nib - NIB_UD_FIRST), MASK_LO, 1'b0}; // see RL7
         end
         2'h2:
         begin
            if (nib == NIB_MODE) l = '{1'b1, IDX_CFG2, MASK_MODE, 1'b1}; // see RL8
            else if (nib >= NIB_UD_FIRST)
               l = '{1'b1, 4'(IDX_UD1 + nib - NIB_UD_FIRST), MASK_HI, 1'b1}; // see RL9
         end
         2'h3:
         begin
            l.used = 1'b0; // see RL1
         end
      endcase
      return l;
   endfunction
endpackage

// [hw/onwd_mirror_mem.sv]
`timescale 1ns/1ps
module onwd_mirror_mem
   import onwd_pkg::*;
#(
   parameter int DEPTH = 16,
   parameter int WIDTH = 8
)(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Masked write port
   input wire logic we,
   input wire logic [3:0] widx,
   input wire logic [WIDTH-1:0] wmask,
   input wire logic [WIDTH-1:0] wdata,
   // Registered read port
   input wire logic [3:0] ridx,
   output logic [WIDTH-1:0] rdata
);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [WIDTH-1:0] next_mem [DEPTH];
   logic [WIDTH-1:0] next_rdata;

   always_comb
   begin
      next_mem = mem;
      // Only masked bits move, so neighbouring fields keep their value
      if (we)
         next_mem[widx] = (mem[widx] & ~wmask) | (wdata & wmask); // see RL14
      next_rdata = mem[ridx];
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         for (int i = 0; i < DEPTH; i++)
            mem[i] <= '0;
         rdata <= '0;
      end
      else
      begin
         mem <= next_mem;
         rdata <= next_rdata;
      end
   end

   neighbour_keep_a: assert property (@(posedge clk) disable iff (!rst_n) // see RL14
      we |=> ((mem[$past(widx)] & ~$past(wmask)) == ($past(mem[widx]) & ~$past(wmask))))
      else $error("bits outside the write mask changed");
endmodule // onwd_mirror_mem

// [hw/onwd_decoder.sv]
// Added by the designer: register access over Wishbone and the register offsets.
`timescale 1ns/1ps
module onwd_decoder
   import onwd_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic [3:0] wb_sel_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // OTP programming request
   output logic otp_prog_valid,
   output logic [3:0] otp_prog_index,
   output logic [7:0] otp_prog_mask,
   output logic [7:0] otp_prog_data,
   output logic [2:0] otp_prog_bits,
   // Current node address
   output logic [3:0] node_address
);
   // ----------------------------------------
   // Declarations
   // ----------------------------------------
   typedef enum {ST_IDLE, ST_WRITE, ST_SETTLE, ST_CAPT} onwd_state_t;
   onwd_state_t state, next_state;
   onwd_cmd_t cmd, next_cmd;
   onwd_loc_t loc;
   logic burn_enable, next_burn_enable;
   logic [1:0] bank_select, next_bank_select;
   logic [1:0] bank_l, next_bank_l;
   logic burn_l, next_burn_l;
   logic [15:0] resp, next_resp;
   logic [3:0] next_node_address;
   logic next_ack;
   logic [31:0] next_dat_o;
   logic next_prog_valid;
   logic [3:0] next_prog_index;
   logic [7:0] next_prog_mask, next_prog_data;
   logic [2:0] next_prog_bits;
   logic mem_we;
   logic [7:0] mem_wdata, mem_rdata;
   logic [3:0] resp_nibble;
   logic bus_req, bus_wr;

   function automatic logic [2:0] onwd_ones(logic [7:0] v);
      logic [2:0] n;
      n = 3'h0;
      for (int i = 0; i < 8; i++)
         n = 3'(n + {2'h0, v[i]});
      return n;
   endfunction

   // ----------------------------------------
   // Location decode and mirror
   // ----------------------------------------
   assign loc = onwd_decode(bank_l, cmd.nibble);
   // Unused locations never reach the mirror
   assign mem_we = (state == ST_WRITE) && loc.used; // see RL1 see RL13
   // Nibble placed on the field's half; the mask keeps only the field
   assign mem_wdata = loc.hi ? {cmd.data, 4'h0} : {4'h0, cmd.data}; // see RL2 see RL3 see RL4
   assign resp_nibble = loc.hi ? mem_rdata[7:4] : mem_rdata[3:0];

   onwd_mirror_mem #(.DEPTH(16), .WIDTH(8)) u_mem (
      .clk(clk),
      .rst_n(rst_n),
      .we(mem_we),
      .widx(loc.idx),
      .wmask(loc.mask),
      .wdata(mem_wdata),
      .ridx(loc.idx),
      .rdata(mem_rdata)
   );

   // ----------------------------------------
   // Bus and sequence
   // ----------------------------------------
   // Requests take effect on the edge that raises ack
   assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign bus_wr = bus_req && wb_we_i && wb_sel_i[0];

   always_comb
   begin
      next_state = state;
      next_cmd = cmd;
      next_burn_enable = burn_enable;
      next_bank_select = bank_select;
      next_bank_l = bank_l;
      next_burn_l = burn_l;
      next_resp = resp;
      next_node_address = node_address;
      next_ack = bus_req;
      next_dat_o = wb_dat_o;
      next_prog_valid = 1'b0;
      next_prog_index = otp_prog_index;
      next_prog_mask = otp_prog_mask;
      next_prog_data = otp_prog_data;
      next_prog_bits = otp_prog_bits;
      if (bus_req)
      begin
         next_dat_o = 32'h0;
         unique case (wb_adr_i)
            REG_CTRL:
            begin
               next_dat_o[CTRL_BURN_BIT] = burn_enable;
               next_dat_o[CTRL_BANK_LSB +: 2] = bank_select;
            end
            REG_CMD:
            begin
               next_dat_o[CMD_DATA_LSB +: 4] = cmd.data;
               next_dat_o[CMD_NIB_LSB +: 4] = cmd.nibble;
            end
            REG_STATUS:
            begin
               next_dat_o[STAT_BUSY_BIT] = (state != ST_IDLE);
               next_dat_o[STAT_BITS_LSB +: 3] = otp_prog_bits;
            end
            REG_RESP: next_dat_o[15:0] = resp;
            REG_NODE: next_dat_o[3:0] = node_address;
            default: next_dat_o = 32'h0;
         endcase
      end
      if (bus_wr && wb_adr_i == REG_CTRL)
      begin
         next_burn_enable = wb_dat_i[CTRL_BURN_BIT];
         next_bank_select = wb_dat_i[CTRL_BANK_LSB +: 2];
      end
      unique case (state)
         ST_IDLE:
         begin
            // A command written while busy is dropped
            if (bus_wr && wb_adr_i == REG_CMD)
            begin
               next_cmd.data = wb_dat_i[CMD_DATA_LSB +: 4];
               next_cmd.nibble = wb_dat_i[CMD_NIB_LSB +: 4];
               next_bank_l = bank_select;
               next_burn_l = burn_enable;
               next_state = ST_WRITE;
            end
         end
         ST_WRITE:
         begin
            if (loc.idx == IDX_CFG2 && loc.mask == MASK_NODE)
               next_node_address = cmd.data; // see RL6
            // Mirror always follows; the array burns only with burn enable
            if (burn_l && loc.used)
            begin
               next_prog_valid = 1'b1; // see RL10
               next_prog_index = loc.idx;
               next_prog_mask = loc.mask;
               next_prog_data = mem_wdata & loc.mask; // see RL14
            end
            // Master must allow one bit time per burned bit
            next_prog_bits = (burn_l && loc.used) ? onwd_ones(mem_wdata & loc.mask) : 3'h0; // see RL12
            next_state = ST_SETTLE;
         end
         ST_SETTLE: next_state = ST_CAPT;
         ST_CAPT:
         begin
            if (!burn_l)
               next_resp = {node_address, RESP_NOBURN_FILL, node_address}; // see RL10
            else if (!loc.used)
               next_resp = {node_address, cmd.nibble, RESP_BURN_TAG, bank_l, node_address}; // see RL1
            else
               next_resp = {node_address, cmd.nibble, RESP_BURN_TAG, bank_l, resp_nibble}; // see RL11
            next_state = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk)
   begin
      if (!rst_n)
      begin
         state <= ST_IDLE;
         cmd <= '0;
         burn_enable <= CTRL_RESET[CTRL_BURN_BIT];
         bank_select <= CTRL_RESET[CTRL_BANK_LSB +: 2];
         bank_l <= 2'h0;
         burn_l <= 1'b0;
         resp <= 16'h0;
         node_address <= NODE_RESET;
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0;
         otp_prog_valid <= 1'b0;
         otp_prog_index <= 4'h0;
         otp_prog_mask <= 8'h0;
         otp_prog_data <= 8'h0;
         otp_prog_bits <= 3'h0;
      end
      else
      begin
         state <= next_state;
         cmd <= next_cmd;
         burn_enable <= next_burn_enable;
         bank_select <= next_bank_select;
         bank_l <= next_bank_l;
         burn_l <= next_burn_l;
         resp <= next_resp;
         node_address <= next_node_address;
         wb_ack_o <= next_ack;
         wb_dat_o <= next_dat_o;
         otp_prog_valid <= next_prog_valid;
         otp_prog_index <= next_prog_index;
         otp_prog_mask <= next_prog_mask;
         otp_prog_data <= next_prog_data;
         otp_prog_bits <= next_prog_bits;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   unused_no_burn_a: assert property ((state == ST_WRITE && bank_l == 2'h3) |=> !otp_prog_valid) // see RL1
      else $error("bank 3 produced a burn");
   lock_bit_a: assert property ((state == ST_WRITE && bank_l == 2'h0 && cmd.nibble == 4'h7) // see RL2
      |-> (mem_we && loc.idx == IDX_CFG2 && loc.mask == 8'h80 && mem_wdata[7] == cmd.data[3]))
      else $error("lock bit location mis-decoded");
   filter_sel_a: assert property ((state == ST_WRITE && bank_l == 2'h0 && cmd.nibble == 4'h8) // see RL3
      |-> (loc.idx == IDX_TYPE && loc.mask == 8'hc0 && mem_wdata[7:6] == cmd.data[3:2]))
      else $error("filter select mis-decoded");
   ident_bit_a: assert property ((state == ST_WRITE && bank_l == 2'h0 && cmd.nibble == 4'ha) // see RL4
      |-> (loc.idx == IDX_CFG0 && loc.mask == 8'h80 && mem_wdata[7] == cmd.data[3]))
      else $error("identity bit mis-decoded");
   trim_field_a: assert property ((state == ST_WRITE && bank_l == 2'h1 && cmd.nibble == 4'h6) // see RL5
      |-> (loc.idx == IDX_CFG1 && loc.mask == 8'h03 && mem_wdata[1:0] == cmd.data[1:0]))
      else $error("trim field mis-decoded");
   node_update_a: assert property ((state == ST_WRITE && bank_l == 2'h1 && cmd.nibble == 4'h7) // see RL6
      |=> ##2 (state == ST_IDLE && resp[15:12] == $past(cmd.data, 3) && node_address == resp[3:0]))
      else $error("node address not updated");
   ud_low_a: assert property ((state == ST_WRITE && bank_l == 2'h1 && cmd.nibble >= 4'h8 // see RL7
      && cmd.nibble <= 4'he) |-> (loc.idx == 4'(cmd.nibble - 4'h4) && loc.mask == 8'h0f))
      else $error("user low nibble mis-decoded");
   mode_bit_a: assert property ((state == ST_WRITE && bank_l == 2'h2 && cmd.nibble == 4'h7) // see RL8
      |-> (loc.idx == IDX_CFG2 && loc.mask == 8'h20 && mem_wdata[5] == cmd.data[1]))
      else $error("mode bit mis-decoded");
   ud_high_a: assert property ((state == ST_WRITE && bank_l == 2'h2 && cmd.nibble >= 4'h8) // see RL9
      |-> (loc.idx == 4'(cmd.nibble - 4'h4) && loc.mask == 8'hf0))
      else $error("user high nibble mis-decoded");
   burn_gate_a: assert property (otp_prog_valid |-> $past(burn_l) && $past(state) == ST_WRITE) // see RL10
      else $error("burn without burn enable");
   noburn_resp_a: assert property ((state == ST_CAPT && !burn_l) // see RL10
      |=> resp == {node_address, 8'h0f, node_address})
      else $error("no-burn response malformed");
   burn_resp_a: assert property ((state == ST_CAPT && burn_l && loc.used) // see RL11
      |=> resp[11:4] == {$past(cmd.nibble), 2'h3, $past(bank_l)} && resp[3:0] == $past(resp_nibble))
      else $error("burn response malformed");
   unused_row_a: assert property ((state == ST_WRITE && cmd.nibble == 4'h6 && bank_l != 2'h1) // see RL13
      |-> !mem_we)
      else $error("empty row wrote the mirror");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");

   burn_write_c: cover property (otp_prog_valid && otp_prog_bits == 3'h4);
   mirror_only_c: cover property (state == ST_CAPT && !burn_l && loc.used);
   unused_burn_c: cover property (state == ST_CAPT && burn_l && !loc.used);
endmodule // onwd_decoder

// [tb/onwd_otp_model.sv]
`timescale 1ns/1ps
// ----------------------------------------
// Burn sink in place of the OTP programming hardware
// ----------------------------------------
module onwd_otp_model
#(
   parameter int T_BIT = 4
)(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Burn request
   input wire logic prog_valid,
   input wire logic [3:0] prog_index,
   input wire logic [7:0] prog_mask,
   input wire logic [7:0] prog_data,
   input wire logic [2:0] prog_bits,
   // Observed burns
   output int n_burn,
   output int n_gap_err,
   output logic [22:0] last_burn
);
   int gap;
   int need;
   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         n_burn <= 0;
         n_gap_err <= 0;
         gap <= 0;
         need <= 0;
         last_burn <= '0;
      end
      else
      begin
         gap <= gap + 1;
         if (prog_valid === 1'b1)
         begin
            // No handshake here, so a burn landing too early is only counted
            if (gap < need)
               n_gap_err <= n_gap_err + 1;
            need <= prog_bits * T_BIT;
            gap <= 1;
            n_burn <= n_burn + 1;
            last_burn <= {prog_index, prog_mask, prog_data, prog_bits};
         end
      end
   end
endmodule // onwd_otp_model

// [tb/tb_top.sv]
`timescale 1ns/1ps
module tb_top
   import onwd_pkg::*;
;
   localparam int T_BIT = 4;
   logic clk = 1'b0, rst_n = 1'b0, wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
   logic [7:0] wb_adr = 8'h00;
   logic [31:0] wb_dat = 32'h0;
   logic [3:0] wb_sel = 4'h0;
   logic [31:0] wb_q;
   logic otp_prog_valid, wb_ack_o;
   logic [31:0] wb_dat_o;
   logic [3:0] otp_prog_index, node_address;
   logic [7:0] otp_prog_mask, otp_prog_data;
   logic [2:0] otp_prog_bits;
   int n_burn, n_gap_err, n_fail = 0, samples_checked = 0, cycles = 0;
   logic [22:0] last_burn;
   logic [7:0] mem [12];
   logic [3:0] node = 4'h0;
   logic [15:0] seed = 16'he956;
   always #10 clk = ~clk;
   function automatic logic [15:0] lfsr_next(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   onwd_decoder dut_u (.clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
      .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_dat_i(wb_dat), .wb_sel_i(wb_sel),
      .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .otp_prog_valid(otp_prog_valid),
      .otp_prog_index(otp_prog_index), .otp_prog_mask(otp_prog_mask),
      .otp_prog_data(otp_prog_data), .otp_prog_bits(otp_prog_bits),
      .node_address(node_address));
   onwd_otp_model #(.T_BIT(T_BIT)) otp_u (.clk(clk), .rst_n(rst_n),
      .prog_valid(otp_prog_valid), .prog_index(otp_prog_index), .prog_mask(otp_prog_mask),
      .prog_data(otp_prog_data), .prog_bits(otp_prog_bits), .n_burn(n_burn),
      .n_gap_err(n_gap_err), .last_burn(last_burn));
   task automatic end_of_test();
      $display("checked %0d, mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      samples_checked++;
      if (got !== exp)
      begin
         n_fail++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   // ----------------------------------------
   // Classic single Wishbone cycle, answer taken at the edge that sees ack
   // ----------------------------------------
   task automatic wb(input logic we, input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] s);
      int k;
      k = 0;
      wb_cyc <= 1'b1;
      wb_stb <= 1'b1;
      wb_we <= we;
      wb_adr <= a;
      wb_dat <= d;
      wb_sel <= s;
      // Ack and data are read at the rising edge, before that edge updates them
      do @(posedge clk); while (wb_ack_o !== 1'b1 && ++k < 50);
      if (k >= 50)
         chk("ack", 32'h1, 32'h0);
      wb_q = wb_dat_o;
      wb_cyc <= 1'b0;
      wb_stb <= 1'b0;
      @(posedge clk);
   endtask
   task automatic poll();
      int k;
      k = 0;
      do wb(1'b0, REG_STATUS, 32'h0, 4'hf); while (wb_q[0] !== 1'b0 && ++k < 20);
      if (wb_q[0] !== 1'b0)
         chk("busy", 32'h0, 32'h1);
   endtask
   // ----------------------------------------
   // One command against the reference mirror
   // ----------------------------------------
   task automatic run_cmd(input logic [1:0] bank, input logic [3:0] nib,
      input logic [3:0] d, input logic burn);
      logic [12:0] l;
      logic [7:0] wv;
      logic [3:0] cont;
      logic [15:0] er;
      int idx, nb, p0;
      l = '0;
      if (bank == 2'h0 && nib == 4'h7) l = {4'h2, 8'h80, 1'b1};
      else if (bank == 2'h0 && nib == 4'h8) l = {4'h3, 8'hc0, 1'b1};
      else if (bank == 2'h0 && nib == 4'ha) l = {4'h0, 8'h80, 1'b1};
      else if (bank == 2'h1 && nib == 4'h6) l = {4'h1, 8'h03, 1'b0};
      else if (bank == 2'h1 && nib == 4'h7) l = {4'h2, 8'h0f, 1'b0};
      else if (bank == 2'h1 && nib >= 4'h8 && nib <= 4'he) l = {nib - 4'h4, 8'h0f, 1'b0};
      else if (bank == 2'h2 && nib == 4'h7) l = {4'h2, 8'h20, 1'b1};
      else if (bank == 2'h2 && nib >= 4'h8) l = {nib - 4'h4, 8'hf0, 1'b1};
      idx = l[12:9];
      wv = (l[0] ? {d, 4'h0} : {4'h0, d}) & l[8:1];
      mem[idx] = (mem[idx] & ~l[8:1]) | wv;
      if (bank == 2'h1 && nib == 4'h7) node = d;
      cont = l[0] ? mem[idx][7:4] : mem[idx][3:0];
      nb = (burn && l[8:1] != 8'h00) ? $countones(wv) : 0;
      er = !burn ? {node, 8'h0f, node} : (l[8:1] != 8'h00) ? {node, nib, 2'b11, bank, cont}
         : {node, nib, 2'b11, bank, node};
      p0 = n_burn;
      wb(1'b1, REG_CTRL, {28'h0, bank, 1'b0, burn}, 4'hf);
      wb(1'b1, REG_CMD, {24'h0, nib, d}, 4'hf);
      poll();
      chk("bits", 32'(nb), 32'(wb_q[6:4]));
      wb(1'b0, REG_RESP, 32'h0, 4'hf);
      chk("resp", {16'h0, er}, {16'h0, wb_q[15:0]});
      chk("node", {28'h0, node}, {28'h0, node_address});
      // A used location burns even when no data bit is one
      chk("burns", 32'(p0 + (burn && l[8:1] != 8'h00)), 32'(n_burn));
      if (burn && l[8:1] != 8'h00)
      begin
         chk("burn", {9'h0, 4'(idx), l[8:1], wv, 3'(nb)}, {9'h0, last_burn});
         repeat (nb * T_BIT) @(posedge clk);
      end
   endtask
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 40000)
      begin
         n_fail++;
         end_of_test();
      end
   end
   initial
   begin
      foreach (mem[i]) mem[i] = 8'h00;
      repeat (8) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      wb(1'b0, REG_NODE, 32'h0, 4'hf);
      chk("node reset", {28'h0, NODE_RESET}, wb_q & 32'hf);
      wb(1'b0, REG_CTRL, 32'h0, 4'hf);
      chk("ctrl reset", CTRL_RESET, wb_q);
      wb(1'b0, 8'h20, 32'h0, 4'hf);
      chk("unmapped", 32'h0, wb_q);
      // Pass without burn fills the mirror that the burn pass reads back
      for (int p = 0; p < 2; p++)
         for (int c = 0; c < 64; c++)
         begin
            seed = lfsr_next(seed);
            run_cmd(2'(c >> 4), 4'(c), seed[3:0], 1'(p));
         end
      run_cmd(2'h1, 4'h7, 4'h9, 1'b1);
      wb(1'b1, REG_CMD, 32'h0000_0075, 4'he);
      poll();
      wb(1'b0, REG_RESP, 32'h0, 4'hf);
      chk("sel ignored", {16'h0, node, 4'h7, 2'b11, 2'h1, node}, {16'h0, wb_q[15:0]});
      wb(1'b0, REG_CMD, 32'h0, 4'hf);
      chk("cmd kept", {24'h0, 4'h7, 4'h9}, wb_q);
      chk("gap", 32'h0, 32'(n_gap_err));
      end_of_test();
   end
endmodule // tb_top
